// *** cbm_master.sv ***
// core bus master: pipelined requests, wait states, error decisions
// Operation
// - bus steps only on enabled clock edges
// - no falling-edge sampling or changes
// - all bus signals on rising clk edge
// - byte, half, three byte, word, double
// - one address cycle, data until ready
// - at most one outstanding, one pending
// - request taken when idle or ready
// - next request may change after acceptance
// - slave error is two cycles
// - pending data request withdrawn on first error cycle; a pending fetch stays queued
// - exception now or deferred
// - fetch error only when instruction used
// - write or demand read error raises exception
// - read request drives attributes, write low
// - new request NONSEQ, taken if idle
// - idle bus gets ready OKAY
// - slave acts on previous address phase
// - no request drives IDLE
// - read data aligned and extended
// - write data held until accepted
// - memory control latches bus signals
// - write high, data after taken
// - held request stays unchanged while waiting
`timescale 1ns/10ps
module cbm_master
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   cbm_bus_if.master        bus,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [31:0] req_addr,
   input  wire logic        req_write,
   input  wire logic [2:0]  req_len,
   input  wire logic        req_signed,
   input  wire logic        req_fetch,
   input  wire logic [5:0]  req_prot,
   input  wire logic [63:0] req_wdata,
   input  wire logic        fetch_use,
   input  wire logic        fetch_flush,
   input  wire logic        defer_exc,
   output logic             rsp_valid,
   output logic [63:0]      rsp_rdata,
   output logic             rsp_error,
   output logic             exc_req
);
   // ------------------------------------------------------------
   // address phase register and data phase tracking
   // ------------------------------------------------------------
   logic        ap_valid, next_ap_valid;
   logic [31:0] ap_addr, next_ap_addr;
   logic        ap_write, next_ap_write;
   logic [2:0]  ap_len, next_ap_len;
   logic        ap_signed, next_ap_signed;
   logic        ap_fetch, next_ap_fetch;
   logic [5:0]  ap_prot, next_ap_prot;
   logic [63:0] ap_wdata, next_ap_wdata;
   logic        dp_valid, next_dp_valid;
   logic        dp_write, next_dp_write;
   logic [2:0]  dp_len, next_dp_len;
   logic [2:0]  dp_lane, next_dp_lane;
   logic        dp_signed, next_dp_signed;
   logic        dp_fetch, next_dp_fetch;
   logic [63:0] wdata, next_wdata;
   logic        fetch_err, next_fetch_err;
   logic        exc_pend, next_exc_pend;
   logic        next_rsp_valid, next_rsp_error, next_exc_req;
   logic [63:0] next_rsp_rdata;

   logic step, taken, done, err1;
   logic [63:0] shifted;

   assign step = bus.ahb_clken;
   assign done = dp_valid & bus.hready;
   assign taken = ap_valid & (~dp_valid | bus.hready);
   // first error cycle: ERROR seen while ready is still low
   assign err1 = dp_valid & ~bus.hready & (bus.hresp == cbm_pkg::RESP_ERROR);
   // new work accepted only when the address slot empties
   assign req_ready = step & (~ap_valid | taken);

   // ------------------------------------------------------------
   // bus outputs
   // ------------------------------------------------------------
   always_comb
   begin
      bus.htrans = ap_valid ? cbm_pkg::TRANS_NONSEQ
                            : cbm_pkg::TRANS_IDLE;
      bus.haddr = ap_addr;
      bus.hburst = cbm_pkg::BURST_SINGLE;
      bus.hprot = ap_prot;
      bus.hwrite = ap_write;
      // three bytes ride a word-sized transfer with three lanes strobed
      bus.hsize = (ap_len == 3'h4) ? 2'h3
                : (ap_len == 3'h3) ? 2'h2 : ap_len[1:0];
      bus.hbstrb = cbm_pkg::cbm_lanes(ap_len, ap_addr[2:0]);
      bus.hwdata = wdata;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_ap_valid = ap_valid;
      next_ap_addr = ap_addr;
      next_ap_write = ap_write;
      next_ap_len = ap_len;
      next_ap_signed = ap_signed;
      next_ap_fetch = ap_fetch;
      next_ap_prot = ap_prot;
      next_ap_wdata = ap_wdata;
      next_dp_valid = dp_valid;
      next_dp_write = dp_write;
      next_dp_len = dp_len;
      next_dp_lane = dp_lane;
      next_dp_signed = dp_signed;
      next_dp_fetch = dp_fetch;
      next_wdata = wdata;
      next_fetch_err = fetch_err;
      next_exc_pend = exc_pend;
      next_rsp_valid = 1'b0;
      next_rsp_error = 1'b0;
      next_rsp_rdata = rsp_rdata;
      next_exc_req = 1'b0;
      shifted = bus.hrdata >> {dp_lane, 3'h0};
      // fetch error waits for use; a flush discards it
      if (fetch_flush)
      begin
         next_fetch_err = 1'b0;
      end
      else if (fetch_use & fetch_err)
      begin
         next_fetch_err = 1'b0;
         next_exc_req = 1'b1;
      end
      if (exc_pend & ~defer_exc)
      begin
         next_exc_pend = 1'b0;
         next_exc_req = 1'b1;
      end
      if (step)
      begin
         if (done)
         begin
            next_dp_valid = 1'b0;
            next_rsp_valid = 1'b1;
            next_rsp_error = (bus.hresp == cbm_pkg::RESP_ERROR);
            unique case (dp_len)
               3'h0: next_rsp_rdata = {{56{dp_signed & shifted[7]}},
                                       shifted[7:0]};
               3'h1: next_rsp_rdata = {{48{dp_signed & shifted[15]}},
                                       shifted[15:0]};
               3'h2: next_rsp_rdata = {{40{dp_signed & shifted[23]}},
                                       shifted[23:0]};
               3'h3: next_rsp_rdata = {{32{dp_signed & shifted[31]}},
                                       shifted[31:0]};
               default: next_rsp_rdata = bus.hrdata;
            endcase
            if (dp_write)
            begin
               next_rsp_rdata = 64'h0;
            end
            if (bus.hresp == cbm_pkg::RESP_ERROR)
            begin
               if (dp_fetch & ~dp_write)
               begin
                  next_fetch_err = 1'b1;
               end
               else if (defer_exc)
               begin
                  next_exc_pend = 1'b1;
               end
               else
               begin
                  next_exc_req = 1'b1;
               end
            end
         end
         if (taken)
         begin
            next_dp_valid = 1'b1;
            next_dp_write = ap_write;
            next_dp_len = ap_len;
            next_dp_lane = ap_addr[2:0];
            next_dp_signed = ap_signed;
            next_dp_fetch = ap_fetch;
            next_wdata = ap_wdata;
            next_ap_valid = 1'b0;
         end
         else if (err1 & ~ap_fetch)
         begin
            // only data requests are withdrawn; fetches stay queued
            next_ap_valid = 1'b0;
         end
         if (req_valid & req_ready)
         begin
            next_ap_valid = 1'b1;
            next_ap_addr = req_addr;
            next_ap_write = req_write;
            next_ap_len = req_len;
            next_ap_signed = req_signed;
            next_ap_fetch = req_fetch;
            next_ap_prot = req_prot;
            next_ap_wdata = req_wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ap_valid <= 1'b0;
         ap_addr <= 32'h0;
         ap_write <= 1'b0;
         ap_len <= 3'h0;
         ap_signed <= 1'b0;
         ap_fetch <= 1'b0;
         ap_prot <= 6'h0;
         ap_wdata <= 64'h0;
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_len <= 3'h0;
         dp_lane <= 3'h0;
         dp_signed <= 1'b0;
         dp_fetch <= 1'b0;
         wdata <= 64'h0;
         fetch_err <= 1'b0;
         exc_pend <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_error <= 1'b0;
         rsp_rdata <= 64'h0;
         exc_req <= 1'b0;
      end
      else
      begin
         ap_valid <= next_ap_valid;
         ap_addr <= next_ap_addr;
         ap_write <= next_ap_write;
         ap_len <= next_ap_len;
         ap_signed <= next_ap_signed;
         ap_fetch <= next_ap_fetch;
         ap_prot <= next_ap_prot;
         ap_wdata <= next_ap_wdata;
         dp_valid <= next_dp_valid;
         dp_write <= next_dp_write;
         dp_len <= next_dp_len;
         dp_lane <= next_dp_lane;
         dp_signed <= next_dp_signed;
         dp_fetch <= next_dp_fetch;
         wdata <= next_wdata;
         fetch_err <= next_fetch_err;
         exc_pend <= next_exc_pend;
         rsp_valid <= next_rsp_valid;
         rsp_error <= next_rsp_error;
         rsp_rdata <= next_rsp_rdata;
         exc_req <= next_exc_req;
      end
   end
endmodule : cbm_master

// *** cbm_pkg.sv ***
// shared constants and types for the core bus master and its slave end
package cbm_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;
   localparam int STRB_W = 8;
   localparam int BURST_W = 3;
   localparam int PROT_W = 6;
   localparam int TRANS_W = 2;
   localparam int SIZE_W = 2;
   localparam int RESP_W = 3;

   localparam logic [1:0] TRANS_IDLE = 2'h0;
   localparam logic [1:0] TRANS_NONSEQ = 2'h2;
   localparam logic [2:0] RESP_OKAY = 3'h0;
   localparam logic [2:0] RESP_ERROR = 3'h1;
   localparam logic [2:0] BURST_SINGLE = 3'h0;

   // access kinds: byte, half, three bytes, word, double word
   typedef enum logic [2:0] {
      CBM_SZ_BYTE = 3'h0,
      CBM_SZ_HALF = 3'h1,
      CBM_SZ_TRI  = 3'h2,
      CBM_SZ_WORD = 3'h3,
      CBM_SZ_DBL  = 3'h4
   } cbm_len_t;

   localparam int SLV_WAIT_DEF = 0;

   function automatic logic [7:0] cbm_lanes(input logic [2:0] len,
                                            input logic [2:0] lane);
      logic [7:0] m;
      m = 8'h00;
      unique case (len)
         3'h0:    m = 8'h01;
         3'h1:    m = 8'h03;
         3'h2:    m = 8'h07;
         3'h3:    m = 8'h0F;
         default: m = 8'hFF;
      endcase
      return (len == 3'h4) ? m : 8'((16'(m) << lane));
   endfunction : cbm_lanes
endpackage : cbm_pkg

// *** cbm_bus_if.sv ***
// bus carrier between the core bus master and the slave end
`timescale 1ns/10ps
interface cbm_bus_if;
   logic [31:0] haddr;
   logic [2:0]  hburst;
   logic [5:0]  hprot;
   logic [1:0]  htrans;
   logic [1:0]  hsize;
   logic [7:0]  hbstrb;
   logic        hwrite;
   logic [63:0] hwdata;
   logic [63:0] hrdata;
   logic        hready;
   logic [2:0]  hresp;
   logic        ahb_clken;

   modport master (output haddr, hburst, hprot, htrans, hsize, hbstrb,
                   hwrite, hwdata, input hrdata, hready, hresp, ahb_clken);
   modport slave (input haddr, hburst, hprot, htrans, hsize, hbstrb,
                  hwrite, hwdata, output hrdata, hready, hresp);
endinterface : cbm_bus_if

// *** cbm_slave.sv ***
// slave end: memory control with wait states and two-cycle error
`timescale 1ns/10ps
module cbm_slave
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   cbm_bus_if.slave         bus,
   input  wire logic        step,
   input  wire logic [3:0]  wait_cycles,
   input  wire logic        fault,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [7:0]       mem_strb,
   output logic [63:0]      mem_wdata,
   input  wire logic [63:0] mem_rdata
);
   // ------------------------------------------------------------
   // latched address phase and response sequencer
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CBM_S_IDLE = 2'b00,
      CBM_S_WAIT = 2'b01,
      CBM_S_ERR2 = 2'b11
   } cbm_sst_t;

   cbm_sst_t    st, next_st;
   logic [31:0] la_addr, next_la_addr;
   logic [7:0]  la_strb, next_la_strb;
   logic        la_write, next_la_write;
   logic        la_fault, next_la_fault;
   logic [3:0]  cnt, next_cnt;
   logic        active;

   assign active = (st != CBM_S_IDLE);
   assign bus.hrdata = mem_rdata;
   assign mem_addr = la_addr;
   assign mem_strb = la_strb;
   assign mem_wdata = bus.hwdata;

   always_comb
   begin
      bus.hready = 1'b1;
      bus.hresp = cbm_pkg::RESP_OKAY;
      mem_we = 1'b0;
      unique case (st)
         CBM_S_IDLE: bus.hready = 1'b1;
         CBM_S_WAIT:
         begin
            bus.hready = (cnt == 4'h0) & ~la_fault;
            bus.hresp = ((cnt == 4'h0) & la_fault) ? cbm_pkg::RESP_ERROR
                                                   : cbm_pkg::RESP_OKAY;
            mem_we = la_write & (cnt == 4'h0) & ~la_fault & step;
         end
         CBM_S_ERR2:
         begin
            bus.hready = 1'b1;
            bus.hresp = cbm_pkg::RESP_ERROR;
         end
      endcase
   end

   always_comb
   begin
      next_st = st;
      next_la_addr = la_addr;
      next_la_strb = la_strb;
      next_la_write = la_write;
      next_la_fault = la_fault;
      next_cnt = cnt;
      if (step)
      begin
         if (st == CBM_S_WAIT & cnt != 4'h0)
         begin
            next_cnt = cnt - 4'h1;
         end
         else if (st == CBM_S_WAIT & la_fault)
         begin
            next_st = CBM_S_ERR2;
         end
         else if (bus.hready | ~active)
         begin
            next_st = CBM_S_IDLE;
            if (bus.htrans == cbm_pkg::TRANS_NONSEQ)
            begin
               next_st = CBM_S_WAIT;
               next_la_addr = bus.haddr;
               next_la_strb = bus.hbstrb;
               next_la_write = bus.hwrite;
               next_la_fault = fault;
               next_cnt = wait_cycles;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= CBM_S_IDLE;
         la_addr <= 32'h0;
         la_strb <= 8'h00;
         la_write <= 1'b0;
         la_fault <= 1'b0;
         cnt <= 4'h0;
      end
      else
      begin
         st <= next_st;
         la_addr <= next_la_addr;
         la_strb <= next_la_strb;
         la_write <= next_la_write;
         la_fault <= next_la_fault;
         cnt <= next_cnt;
      end
   end
endmodule : cbm_slave

// *** cbm_properties.sv ***
// bus-level properties of the core bus master and its slave end
`timescale 1ns/10ps
module cbm_properties
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic [31:0] haddr,
   input wire logic [2:0]  hburst,
   input wire logic [5:0]  hprot,
   input wire logic [1:0]  htrans,
   input wire logic [1:0]  hsize,
   input wire logic [7:0]  hbstrb,
   input wire logic        hwrite,
   input wire logic [63:0] hwdata,
   input wire logic [63:0] hrdata,
   input wire logic        hready,
   input wire logic [2:0]  hresp,
   input wire logic        ahb_clken
);
   logic dphase;
   logic dwrite;
   logic next_dphase;
   logic next_dwrite;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // ------------------------------------------------------------
   // data phase tracker
   // ------------------------------------------------------------
   always_comb
   begin
      next_dphase = dphase;
      next_dwrite = dwrite;
      if (ahb_clken && (!dphase || hready))
      begin
         next_dphase = (htrans == cbm_pkg::TRANS_NONSEQ);
         next_dwrite = hwrite;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dphase <= 1'b0;
         dwrite <= 1'b0;
      end
      else
      begin
         dphase <= next_dphase;
         dwrite <= next_dwrite;
      end
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   AST_RESET_IDLE:
      assert property ($rose(reset_n) |-> htrans == cbm_pkg::TRANS_IDLE)
      else $error("request on bus right after reset");
   AST_CLKEN_HOLD:
      assert property (!ahb_clken |=> $stable(htrans) && $stable(haddr)
                       && $stable(hwrite) && $stable(hwdata))
      else $error("bus output moved on a disabled edge");
   // the first error cycle may legally withdraw the pending request
   AST_PEND_HOLD:
      assert property (htrans == cbm_pkg::TRANS_NONSEQ && dphase && !hready
                       && hresp != cbm_pkg::RESP_ERROR
                       |=> htrans == cbm_pkg::TRANS_NONSEQ && $stable(haddr)
                       && $stable(hbstrb) && $stable(hwrite))
      else $error("waiting request changed");
   AST_WDATA_HOLD:
      assert property (dphase && dwrite && !hready |=> $stable(hwdata))
      else $error("write data changed before acceptance");
   AST_ERR_TWO:
      assert property (hresp == cbm_pkg::RESP_ERROR && !hready && ahb_clken
                       |=> hresp == cbm_pkg::RESP_ERROR && hready)
      else $error("error response not two cycles");
   AST_IDLE_OK:
      assert property (!dphase |-> hready && hresp == cbm_pkg::RESP_OKAY)
      else $error("idle bus without ready okay");
   AST_LANES:
      assert property (htrans == cbm_pkg::TRANS_NONSEQ
                       |-> hburst == cbm_pkg::BURST_SINGLE
                       && ($countones(hbstrb) == (32'h1 << hsize)
                       || (hsize == 2'h2 && $countones(hbstrb) == 3)))
      else $error("strobes do not match size");
   AST_DPHASE_END:
      assert property (dphase |-> ##[0:300] (hready && ahb_clken))
      else $error("data phase never completed");
endmodule : cbm_properties

// *** test_core_ahb_master_bus_interface.sv ***
// self-checking bench for the core bus master facing its slave end
`timescale 1ns/10ps
module test_core_ahb_master_bus_interface;
   logic         clk, reset_n, req_valid, req_ready, req_write, req_signed;
   logic         req_fetch, fetch_use, fetch_flush, defer_exc, rsp_valid;
   logic         rsp_error, exc_req, fault, mem_we, rdy_s, cke_rand;
   logic [2:0]   req_len;
   logic [3:0]   wait_cycles;
   logic [5:0]   req_prot;
   logic [7:0]   mem_strb;
   logic [31:0]  req_addr, mem_addr;
   logic [63:0]  req_wdata, rsp_rdata, mem_wdata, mem_rdata;
   logic [64:0]  rq[$];
   logic [104:0] wq[$];
   int           error_cnt, comparisons, exc_cnt;

   cbm_bus_if bus ();
   cbm_master u_cbm_master
   (
      .clk, .reset_n, .bus, .req_valid, .req_ready, .req_addr, .req_write,
      .req_len, .req_signed, .req_fetch, .req_prot, .req_wdata, .fetch_use,
      .fetch_flush, .defer_exc, .rsp_valid, .rsp_rdata, .rsp_error, .exc_req
   );
   cbm_slave u_cbm_slave
   (
      .clk, .reset_n, .bus, .step(bus.ahb_clken), .wait_cycles, .fault,
      .mem_we, .mem_addr, .mem_strb, .mem_wdata, .mem_rdata
   );
   cbm_properties u_cbm_properties
   (
      .clk, .reset_n, .haddr(bus.haddr), .hburst(bus.hburst),
      .hprot(bus.hprot), .htrans(bus.htrans), .hsize(bus.hsize),
      .hbstrb(bus.hbstrb), .hwrite(bus.hwrite), .hwdata(bus.hwdata),
      .hrdata(bus.hrdata), .hready(bus.hready), .hresp(bus.hresp),
      .ahb_clken(bus.ahb_clken)
   );

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // irregular bus enable while cke_rand is set
   always @(posedge clk)
   begin
      #1;
      bus.ahb_clken = cke_rand ? ($urandom % 4 != 0) : 1'b1;
   end

   // ------------------------------------------------------------
   // checking
   // ------------------------------------------------------------
   task automatic report(input logic [104:0] got, input logic [104:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : report

   task automatic chk_rsp(input logic [64:0] got, input logic [64:0] exp);
      report(105'(exp[64] ? {got[64], 64'h0} : got), 105'(exp));
   endtask : chk_rsp

   // top bit only marks a double word; address, lanes and data all compared
   task automatic chk_wr(input logic [103:0] got, input logic [104:0] exp);
      report({exp[104], got}, exp);
   endtask : chk_wr

   task automatic chk_cnt(input int exp);
      report(105'(exc_cnt), 105'(exp));
   endtask : chk_cnt

   always @(negedge clk)
   begin
      rdy_s = req_ready;
      if (exc_req === 1'b1)
         exc_cnt++;
      if (rsp_valid === 1'b1)
         chk_rsp({rsp_error, rsp_rdata}, rq.pop_front());
      if (mem_we === 1'b1 && bus.hready === 1'b1 && bus.ahb_clken === 1'b1)
         chk_wr({mem_addr, mem_strb, mem_wdata}, wq.pop_front());
   end

   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   task automatic issue(input logic w, input logic [2:0] len,
                        input logic fc);
      logic [63:0] m;
      logic [63:0] v;
      logic [2:0]  ln;
      int          nb;
      int          n;
      nb = (len == 3'h4) ? 8 : int'(len) + 1;
      ln = 3'($urandom % (9 - nb));
      m = (64'h1 << (8 * nb)) - 64'h1;
      req_valid = 1'b1;
      req_addr = {29'($urandom), ln};
      req_write = w;
      req_len = len;
      req_signed = 1'($urandom);
      req_fetch = fc;
      req_prot = 6'($urandom);
      req_wdata = {$urandom, $urandom};
      wait_cycles = 4'($urandom % 3);
      v = (mem_rdata >> (8 * ln)) & m;
      if (req_signed && v[8 * nb - 1])
         v = v | ~m;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (!rdy_s && n < 500);
      // a request never taken is a hang, not a pass
      if (!rdy_s)
         error_cnt++;
      rq.push_back(fault ? {1'b1, 64'h0} : (w ? 65'h0 : {1'b0, v}));
      if (w && !fault)
         wq.push_back({len == 3'h4, req_addr, 8'(((1 << nb) - 1) << ln),
                       req_wdata});
      #1;
   endtask : issue

   task automatic settle();
      int n;
      req_valid = 1'b0;
      n = 0;
      while ((rq.size() != 0 || wq.size() != 0) && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      if (rq.size() != 0 || wq.size() != 0)
         error_cnt++;
      repeat (4) @(posedge clk);
      #1;
   endtask : settle

   task automatic pulse(input logic u, input logic f);
      fetch_use = u;
      fetch_flush = f;
      @(posedge clk);
      #1;
      fetch_use = 1'b0;
      fetch_flush = 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : pulse

   task automatic summarize();
      $display("mismatches %0d of %0d comparisons", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize

   initial
   begin
      #100000;
      error_cnt++;
      summarize();
   end

   initial
   begin
      {reset_n, req_valid, req_write, req_signed, req_fetch} = 5'h00;
      {fetch_use, fetch_flush, defer_exc, fault, cke_rand} = 5'h00;
      {req_len, wait_cycles, req_prot, req_addr} = 45'h0;
      {req_wdata, mem_rdata} = 128'h0;
      {error_cnt, comparisons, exc_cnt} = {32'h0, 32'h0, 32'h0};
      void'($urandom(32'h40BDB51D));
      repeat (12) @(posedge clk);
      #1;
      reset_n = 1'b1;
      cke_rand = 1'b1;
      mem_rdata = {$urandom, $urandom};
      for (int i = 0; i < 60; i++)
         issue(1'($urandom), 3'(i % 5), 1'b0);
      settle();
      cke_rand = 1'b0;
      fault = 1'b1;
      issue(1'b0, 3'h3, 1'b0);
      settle();
      chk_cnt(1);
      defer_exc = 1'b1;
      issue(1'b1, 3'h4, 1'b0);
      settle();
      chk_cnt(1);
      defer_exc = 1'b0;
      repeat (3) @(posedge clk);
      chk_cnt(2);
      #1;
      issue(1'b0, 3'h2, 1'b1);
      settle();
      chk_cnt(2);
      pulse(1'b1, 1'b0);
      chk_cnt(3);
      issue(1'b0, 3'h0, 1'b1);
      settle();
      pulse(1'b0, 1'b1);
      pulse(1'b1, 1'b0);
      chk_cnt(3);
      fault = 1'b0;
      summarize();
   end
endmodule : test_core_ahb_master_bus_interface
